// >>> src/cdsc_pkg.sv
package cdsc_pkg;
  localparam int unsigned NODES = 2;
  localparam logic [7:0] ADR_CTL0 = 8'h00;
  localparam logic [7:0] ADR_CTL1 = 8'h04;
  localparam logic [7:0] ADR_STS0 = 8'h08;
  localparam logic [7:0] ADR_STS1 = 8'h0c;
  localparam logic [7:0] ADR_SUSP_CFG = 8'h10;
  localparam int unsigned CTL_INIT = 0;
  localparam int unsigned CTL_SENS = 1;
  localparam int unsigned CTL_DIS = 2;
  localparam int unsigned STS_ACK = 0;
  localparam int unsigned STS_IDLE = 1;
  localparam int unsigned STS_INIT_EFF = 2;
  localparam int unsigned STS_BOFF = 3;
  localparam logic [2:0] CTL_RST = 3'h1;
  localparam logic [1:0] SUSP_CFG_RST = 2'h0;
  localparam int unsigned SUSP_CFG_STOP_BIT = 1;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cdsc_bus_t;
  typedef struct packed {
    logic idle;
    logic boff;
    logic in_frame;
  } cdsc_node_st_t;
endpackage : cdsc_pkg

// >>> src/cdsc_node.sv
`timescale 1ns/1ps
module cdsc_node
  import cdsc_pkg::*;
(
  input  wire logic          clk_sys_in,
  input  wire logic          sys_rst_in,
  input  wire logic          init_sw_in,
  input  wire logic          sens_in,
  input  wire logic          dis_in,
  input  wire logic          susp_in,
  input  wire cdsc_node_st_t st_in,
  output logic               init_eff_out,
  output logic               ack_out
);
  // Stop point is bus idle or bus off; a running frame is never cut
  wire stop_pt = (st_in.idle | st_in.boff) & ~st_in.in_frame;
  wire want    = (susp_in & sens_in) | dis_in;
  logic forced;
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      forced  <= 1'b0;
      ack_out <= 1'b0;
    end else begin
      forced  <= want & (forced | stop_pt);
      ack_out <= want & (forced | stop_pt);
    end
  end
  assign init_eff_out = init_sw_in | forced;

  AST_NO_CUT: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (!forced && st_in.in_frame) |=> !forced)
    else $error("node forced while frame running");
  AST_ACK_IDLE: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    ($rose(ack_out)) |-> $past(stop_pt))
    else $error("ack set away from idle or bus off");
  AST_DIS_ACK: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (dis_in && stop_pt) |=> ack_out)
    else $error("disabled node did not ack at idle");
  AST_RELEASE: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (!want) |=> (!forced && !ack_out))
    else $error("force not released");
endmodule : cdsc_node

// >>> src/cdsc_top.sv
`timescale 1ns/1ps
// What this block does
// - Each node has a software suspend sensitivity bit in its control register.
// - Sensitive node under suspend gets init forced at bus idle or bus off.
// - Running frame completes, no new frame starts, bus not blocked.
// - Graceful suspend keeps clock running; registers stay accessible.
// - Suspend acknowledge sets only once idle or bus off reached.
// - Config 1X gates module clock when suspend request goes active.
// - Immediate stop aborts activity and drives all transmit outputs recessive.
// - Node disable bit waits for bus idle or bus off then sets acknowledge.
module cdsc_top
  import cdsc_pkg::*;
(
  input  wire logic                     clk_sys_in,
  input  wire logic                     sys_rst_in,
  input  wire logic [7:0]               addr_in,
  input  wire logic [31:0]              wdata_in,
  input  wire logic                     wr_in,
  input  wire logic                     rd_in,
  output logic [31:0]                   rdata_out,
  input  wire logic                     susp_req_in,
  input  wire cdsc_pkg::cdsc_node_st_t  node_st_in [NODES],
  input  wire logic [NODES-1:0]         core_txd_in,
  output logic [NODES-1:0]              txd_out,
  output logic [NODES-1:0]              node_init_out,
  output logic                          clk_gate_en_out
);
  import cdsc_pkg::*;

  logic [2:0]       ctl [NODES];
  logic [1:0]       susp_cfg;
  logic [NODES-1:0] init_eff;
  logic [NODES-1:0] ack;

  // Clock runs unless stop mode selected and suspend active
  wire stop_now = susp_req_in & susp_cfg[SUSP_CFG_STOP_BIT];

  genvar g;
  generate
    for (g = 0; g < NODES; g++) begin : gen_node
      cdsc_node u_node (
        .clk_sys_in   (clk_sys_in),
        .sys_rst_in   (sys_rst_in),
        .init_sw_in   (ctl[g][CTL_INIT]),
        .sens_in      (ctl[g][CTL_SENS]),
        .dis_in       (ctl[g][CTL_DIS]),
        .susp_in      (susp_req_in),
        .st_in        (node_st_in[g]),
        .init_eff_out (init_eff[g]),
        .ack_out      (ack[g])
      );
      // A node that is not in init (software or forced) and not stopped passes its core line through unchanged
      AST_TXD_PASS: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        (!stop_now && !init_eff[g]) |=> (txd_out[g] == $past(core_txd_in[g])))
        else $error("transmit line not passed through");
    end
  endgenerate

  function automatic logic [31:0] sts_word(input logic a, input cdsc_node_st_t s, input logic ie);
    sts_word = 32'h0;
    sts_word[STS_ACK]      = a;
    sts_word[STS_IDLE]     = s.idle;
    sts_word[STS_INIT_EFF] = ie;
    sts_word[STS_BOFF]     = s.boff;
  endfunction : sts_word

  // Registers stay live during graceful suspend since clock is not gated
  wire [31:0] rd_mux =
    (addr_in == ADR_CTL0)     ? {29'h0, ctl[0]} :
    (addr_in == ADR_CTL1)     ? {29'h0, ctl[1]} :
    (addr_in == ADR_STS0)     ? sts_word(ack[0], node_st_in[0], init_eff[0]) :
    (addr_in == ADR_STS1)     ? sts_word(ack[1], node_st_in[1], init_eff[1]) :
    (addr_in == ADR_SUSP_CFG) ? {30'h0, susp_cfg} : RD_UNMAPPED;

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ctl[0]          <= CTL_RST;
      ctl[1]          <= CTL_RST;
      susp_cfg        <= SUSP_CFG_RST;
      rdata_out       <= 32'h0;
      txd_out         <= '1;
      node_init_out   <= '1;
      clk_gate_en_out <= 1'b1;
    end else begin
      // Writes while stopped are dropped; behaviour there is undefined anyway
      if (wr_in && !stop_now) begin
        if (addr_in == ADR_CTL0) ctl[0] <= wdata_in[2:0];
        if (addr_in == ADR_CTL1) ctl[1] <= wdata_in[2:0];
        if (addr_in == ADR_SUSP_CFG) susp_cfg <= wdata_in[1:0];
      end
      rdata_out       <= rd_in ? rd_mux : 32'h0;
      clk_gate_en_out <= ~stop_now;
      // Forced init nodes and stopped module send recessive only
      txd_out         <= stop_now ? '1 : (core_txd_in | init_eff);
      node_init_out   <= init_eff;
    end
  end

  AST_STOP_GATE: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (susp_req_in && susp_cfg[SUSP_CFG_STOP_BIT]) |=> !clk_gate_en_out)
    else $error("clock not gated in stop mode");
  AST_STOP_RECESSIVE: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (susp_req_in && susp_cfg[SUSP_CFG_STOP_BIT]) |=> (txd_out == '1))
    else $error("transmit not recessive in stop");
  AST_GRACEFUL_CLK: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (!susp_cfg[SUSP_CFG_STOP_BIT]) |=> clk_gate_en_out)
    else $error("clock gated in graceful mode");
  AST_UNGATE: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    $fell(susp_req_in) |=> clk_gate_en_out)
    else $error("clock not restored");
  AST_RD_DATA: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (rd_in && addr_in == ADR_SUSP_CFG) |=> (rdata_out == {30'h0, $past(susp_cfg)}))
    else $error("read data wrong");
  AST_SENS_WR: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (wr_in && !stop_now && addr_in == ADR_CTL0) |=> (ctl[0][CTL_SENS] == $past(wdata_in[1])))
    else $error("sensitivity bit not written");
endmodule : cdsc_top

// >>> test/cdsc_core_model.sv
`timescale 1ns/1ps
module cdsc_core_model
  import cdsc_pkg::*;
(
  input  wire logic             clk_sys_in,
  input  wire logic [NODES-1:0] busy_in,
  output cdsc_node_st_t         st_out [NODES],
  output logic [NODES-1:0]      txd_out
);
  integer seed = 32'hc4ac;
  initial begin
    txd_out = '1;
    foreach (st_out[i]) st_out[i] = '{1'b1, 1'b0, 1'b0};
  end
  // A node in a frame is never idle and its line changes at random
  always @(posedge clk_sys_in) begin
    for (int i = 0; i < NODES; i++) begin
      st_out[i] <= '{!busy_in[i], 1'b0, busy_in[i]};
      txd_out[i] <= busy_in[i] ? 1'($random(seed)) : 1'b1;
    end
  end
endmodule : cdsc_core_model

// >>> test/test_can_debug_suspend_control.sv
`timescale 1ns/1ps
module test_can_debug_suspend_control;
  import cdsc_pkg::*;
  logic             clk_sys_in = 0, sys_rst_in = 1, wr_in = 0, rd_in = 0, susp_req_in = 0;
  logic [7:0]       addr_in = '0;
  logic [31:0]      wdata_in = '0, rdata_out, rv;
  logic [NODES-1:0] busy = '0, core_txd_in, txd_out, node_init_out;
  logic             clk_gate_en_out;
  cdsc_node_st_t    node_st_in [NODES];
  int               error_cnt = 0, checks = 0;
  cdsc_top uut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .susp_req_in(susp_req_in), .node_st_in(node_st_in),
    .core_txd_in(core_txd_in), .txd_out(txd_out), .node_init_out(node_init_out),
    .clk_gate_en_out(clk_gate_en_out));
  cdsc_core_model far (.clk_sys_in(clk_sys_in), .busy_in(busy), .st_out(node_st_in), .txd_out(core_txd_in));
  initial forever #12.5 clk_sys_in = ~clk_sys_in;
  function logic [31:0] sts_exp(input logic a, i, n);
    return {29'h0, n, i, a};
  endfunction : sts_exp
  task chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in); addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
    @(posedge clk_sys_in); wr_in <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk_sys_in); addr_in <= a; rd_in <= 1'b1;
    @(posedge clk_sys_in); rd_in <= 1'b0;
    #1 rv = rdata_out;
  endtask : rd
  task test_done;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (4000) @(posedge clk_sys_in);
    error_cnt++;
    test_done;
  end
  initial begin
    repeat (5) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    rd(ADR_SUSP_CFG); chk("cfg", 32'(SUSP_CFG_RST), rv);
    wr(ADR_CTL0, 32'h2); wr(ADR_CTL1, 32'h0);
    rd(ADR_CTL0); chk("ctl0", 32'h2, rv);
    // Frame must be seen running before the request, or the idle status of the same edge lets the force in
    @(posedge clk_sys_in); busy <= 2'b11;
    @(posedge clk_sys_in); susp_req_in <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    rd(ADR_STS0); chk("sts0", sts_exp(0, 0, 0), rv & 32'h7);
    chk("init", 32'h0, 32'(node_init_out));
    @(posedge clk_sys_in); busy <= 2'b00;
    repeat (4) @(posedge clk_sys_in);
    rd(ADR_STS0); chk("sts0", sts_exp(1, 1, 1), rv & 32'h7);
    chk("init", 32'h1, 32'(node_init_out));
    @(posedge clk_sys_in); busy <= 2'b01;
    repeat (6) @(posedge clk_sys_in);
    #1 chk("txd0", 32'h1, 32'(txd_out[0]));
    wr(ADR_CTL1, 32'h4); rd(ADR_CTL1); chk("ctl1", 32'h4, rv);
    chk("gate", 32'h1, 32'(clk_gate_en_out));
    rd(ADR_STS1); chk("ack1", 32'h1, rv & 32'h1);
    @(posedge clk_sys_in); susp_req_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    #1 chk("init0", 32'h0, 32'(node_init_out[0]));
    wr(ADR_CTL1, 32'h0);
    for (int c = 1; c < 4; c++) begin
      wr(ADR_SUSP_CFG, 32'(c));
      @(posedge clk_sys_in); busy <= 2'b11; susp_req_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      #1 chk("gate", 32'(c < 2), 32'(clk_gate_en_out));
      if (c > 1) chk("txd", 32'h3, 32'(txd_out));
      @(posedge clk_sys_in); susp_req_in <= 1'b0; busy <= 2'b00;
      repeat (3) @(posedge clk_sys_in);
      #1 chk("gate", 32'h1, 32'(clk_gate_en_out));
    end
    @(posedge clk_sys_in); sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in); sys_rst_in <= 1'b0;
    rd(ADR_SUSP_CFG); chk("cfg", 32'h0, rv);
    test_done;
  end
endmodule : test_can_debug_suspend_control
